// [hw/pwg_wave_gen.sv]
`timescale 1ns/1ns
`include "pwg_defs.svh"

// Behaviour
// - Control bit 7 runs the modulator and period counter; cleared stops it.
// - Polarity zero drives output high for duty, low for the rest.
// - Polarity one drives output low for duty, high for the rest.
// - Divider field bits 5-4 gives tick of clock over 2, 4, 8, 16.
// - Hardware sets control bit 1 whenever the period counter wraps.
// - Share bit zero leaves pin as plain I/O; one drives the waveform.
// - One period lasts period value times divided tick period.
// - Period 00H holds output at inactive level for either polarity.
// - Duty value sets active length at the start of each period.
// - Nonzero period not above duty holds output at active level.
// - Duty 00H holds output at inactive level.
// - Wrap flag raises the interrupt only while interrupt allow is set.
// - Enabled with pin released, counter still runs as a timer.
module pwg_wave_gen (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Avalon-MM slave
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Port logic of the shared pin
    input wire logic gpioOut,
    input wire logic gpioOe,
    output logic pinOut,
    output logic pinOe,
    // Waveform and interrupt
    output logic waveOut,
    output logic irq
);

    // ============================================================
    // Registers
    logic moduleOn;
    logic polaritySel;
    pwg_pkg::pwg_div_t tickDivSel;
    logic periodWrapFlag;
    logic pinShareSel;
    logic [7:0] periodLength;
    logic [7:0] dutyLength;
    logic waveIrqAllow;

    // Running state
    logic [7:0] cnt;
    logic [7:0] perAct;
    logic [7:0] dutyAct;

    pwg_tick_if tk ();

    // ============================================================
    // Bus decode
    logic busReq;
    logic wrEn;
    logic lane0;
    logic [7:0] regIdx;
    logic hitCtrl;
    logic hitPeriod;
    logic hitDuty;
    logic hitMask;
    logic hitStatus;
    logic wrCtrl;
    logic wrPeriod;
    logic wrDuty;
    logic wrMask;
    logic wrStatus;
    logic [7:0] ctrlView;
    logic [7:0] rdByte;

    assign busReq = avs_read || avs_write;
    assign wrEn = avs_write && !avs_waitrequest;
    assign lane0 = avs_byteenable[0];
    assign regIdx = avs_address[9:2];
    assign hitCtrl = (regIdx == `PWG_IDX_CTRL);
    assign hitPeriod = (regIdx == `PWG_IDX_PERIOD);
    assign hitDuty = (regIdx == `PWG_IDX_DUTY);
    assign hitMask = (regIdx == `PWG_IDX_MASK);
    assign hitStatus = (regIdx == `PWG_IDX_STATUS);
    assign wrCtrl = wrEn && lane0 && hitCtrl;
    assign wrPeriod = wrEn && lane0 && hitPeriod;
    assign wrDuty = wrEn && lane0 && hitDuty;
    assign wrMask = wrEn && lane0 && hitMask;
    assign wrStatus = wrEn && lane0 && hitStatus;

    // Control register as read; bits 3-2 read as zero
    assign ctrlView = {moduleOn, polaritySel, tickDivSel, 2'b00,
                       periodWrapFlag, pinShareSel};

    // Read mux, unmapped addresses read zero
    assign rdByte = hitCtrl ? ctrlView :
                    hitPeriod ? periodLength :
                    hitDuty ? dutyLength :
                    hitMask ? {7'h00, waveIrqAllow} :
                    hitStatus ? {7'h00, periodWrapFlag} : 8'h00;

    // Waitrequest drops one cycle after a request, for one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (ce) begin
            avs_waitrequest <= !(busReq && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= {24'h00_0000, rdByte};
            end
        end
    end

    // ============================================================
    // Software registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {moduleOn, polaritySel} <= 2'b00;
            tickDivSel <= pwg_pkg::PWG_DIV2;
            pinShareSel <= 1'b0;
            periodLength <= `PWG_RST_PERIOD;
            dutyLength <= `PWG_RST_DUTY;
            waveIrqAllow <= `PWG_RST_MASK;
        end else if (ce) begin
            if (wrCtrl) begin
                moduleOn <= avs_writedata[`PWG_CTRL_ON];
                polaritySel <= avs_writedata[`PWG_CTRL_POL];
                tickDivSel <= pwg_pkg::pwg_div_t'(
                    avs_writedata[`PWG_CTRL_DIV_HI:`PWG_CTRL_DIV_LO]);
                pinShareSel <= avs_writedata[`PWG_CTRL_SHARE];
            end
            if (wrPeriod) begin
                periodLength <= avs_writedata[7:0];
            end
            if (wrDuty) begin
                dutyLength <= avs_writedata[7:0];
            end
            if (wrMask) begin
                waveIrqAllow <= avs_writedata[`PWG_IRQ_WRAP];
            end
        end
    end

    // ============================================================
    // Prescaler
    assign tk.run = moduleOn;
    assign tk.div = tickDivSel;

    pwg_prescaler u_presc (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .tk(tk)
    );

    // ============================================================
    // Period counter and boundary
    logic atEnd;
    logic wrapEvt;
    logic boundary;

    assign atEnd = (perAct != 8'h00) && (cnt >= perAct - 8'h01);
    assign wrapEvt = tk.tick && atEnd;
    assign boundary = !moduleOn || (tk.tick && (atEnd || perAct == 8'h00));

    // Counter wraps after period ticks, also with pin released
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
        end else if (ce) begin
            if (!moduleOn || wrapEvt) begin
                cnt <= 8'h00;
            end else if (tk.tick && perAct != 8'h00) begin
                cnt <= cnt + 8'h01;
            end
        end
    end

    // Working copies reload at a period boundary and every cycle while stopped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            perAct <= `PWG_RST_PERIOD;
            dutyAct <= `PWG_RST_DUTY;
        end else if (ce && boundary) begin
            perAct <= periodLength;
            dutyAct <= dutyLength;
        end
    end

    // ============================================================
    // Wrap flag; a set in the same cycle as a clear wins
    logic clrCtrl;
    logic clrStat;
    logic next_flag;

    assign clrCtrl = wrCtrl && !avs_writedata[`PWG_CTRL_FLAG];
    assign clrStat = wrStatus && avs_writedata[`PWG_IRQ_WRAP];
    assign next_flag = wrapEvt || (periodWrapFlag && !clrCtrl && !clrStat);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periodWrapFlag <= 1'b0;
        end else if (ce) begin
            periodWrapFlag <= next_flag;
        end
    end

    // ============================================================
    // Waveform level
    logic activeLvl;
    logic next_wave;

    assign activeLvl = (perAct == 8'h00) ? 1'b0 :
                       (perAct <= dutyAct) ? 1'b1 :
                       (cnt < dutyAct);
    assign next_wave = moduleOn ? (activeLvl ^ polaritySel)
                                : polaritySel;

    // Output flops: waveform, shared pin and interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waveOut <= 1'b0;
            pinOut <= 1'b0;
            pinOe <= 1'b0;
            irq <= 1'b0;
        end else if (ce) begin
            waveOut <= next_wave;
            pinOut <= pinShareSel ? next_wave : gpioOut;
            pinOe <= pinShareSel || gpioOe;
            irq <= periodWrapFlag && waveIrqAllow;
        end
    end

    // ============================================================
    // Checks
    property p_off_idle;
        @(posedge clk) disable iff (!rst_n)
        ce && !moduleOn |=> cnt == 8'h00 && waveOut == $past(polaritySel);
    endproperty
    a_off_idle: assert property (p_off_idle)
        else $error("stopped module not idle");

    property p_pol_active;
        @(posedge clk) disable iff (!rst_n)
        ce && moduleOn && activeLvl |=> waveOut == !$past(polaritySel);
    endproperty
    a_pol_active: assert property (p_pol_active)
        else $error("duty level wrong for polarity");

    property p_zero_period;
        @(posedge clk) disable iff (!rst_n)
        ce && moduleOn && perAct == 8'h00
            |=> waveOut == $past(polaritySel);
    endproperty
    a_zero_period: assert property (p_zero_period)
        else $error("zero period not inactive");

    property p_full_duty;
        @(posedge clk) disable iff (!rst_n)
        ce && moduleOn && perAct != 8'h00 && perAct <= dutyAct
            |=> waveOut != $past(polaritySel);
    endproperty
    a_full_duty: assert property (p_full_duty)
        else $error("period not above duty must stay active");

    property p_zero_duty;
        @(posedge clk) disable iff (!rst_n)
        ce && moduleOn && dutyAct == 8'h00
            |=> waveOut == $past(polaritySel);
    endproperty
    a_zero_duty: assert property (p_zero_duty)
        else $error("zero duty not inactive");

    property p_wrap;
        @(posedge clk) disable iff (!rst_n)
        ce && wrapEvt |=> periodWrapFlag && cnt == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not set flag and clear count");

    property p_flag_hold;
        @(posedge clk) disable iff (!rst_n)
        periodWrapFlag && !(ce && (clrCtrl || clrStat)) |=> periodWrapFlag;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("wrap flag lost without a clear");

    property p_irq;
        @(posedge clk) disable iff (!rst_n)
        ce |=> irq == ($past(periodWrapFlag) && $past(waveIrqAllow));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow flag and allow");

    property p_share;
        @(posedge clk) disable iff (!rst_n)
        ce && !pinShareSel |=> pinOut == $past(gpioOut)
            && pinOe == $past(gpioOe);
    endproperty
    a_share: assert property (p_share)
        else $error("released pin not following port logic");

    property p_shadow;
        @(posedge clk) disable iff (!rst_n)
        ce && !boundary |=> perAct == $past(perAct)
            && dutyAct == $past(dutyAct);
    endproperty
    a_shadow: assert property (p_shadow)
        else $error("period or duty changed mid period");

    property p_bus_answer;
        @(posedge clk) disable iff (!rst_n)
        ce && busReq && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus request not answered in one cycle");

endmodule

// [hw/pwg_defs.svh]
`ifndef PWG_DEFS_SVH
`define PWG_DEFS_SVH

// ============================================================
// Register indices; byte address is four times the index
`define PWG_IDX_CTRL 8'hd1
`define PWG_IDX_PERIOD 8'hd2
`define PWG_IDX_DUTY 8'hd3
`define PWG_IDX_MASK 8'hd4
`define PWG_IDX_STATUS 8'hd5

// ============================================================
// Field positions in wave_control
`define PWG_CTRL_ON 7
`define PWG_CTRL_POL 6
`define PWG_CTRL_DIV_HI 5
`define PWG_CTRL_DIV_LO 4
`define PWG_CTRL_FLAG 1
`define PWG_CTRL_SHARE 0

// Field positions in the mask and status registers
`define PWG_IRQ_WRAP 0

// ============================================================
// Reset values
`define PWG_RST_CTRL 8'h00
`define PWG_RST_PERIOD 8'h00
`define PWG_RST_DUTY 8'h00
`define PWG_RST_MASK 1'b0

// ============================================================
// Timing: cycles from request to waitrequest low
`define PWG_BUS_LATENCY 1

`endif

// [hw/pwg_pkg.sv]
package pwg_pkg;

    // Divider select codes, in register order
    typedef enum logic [1:0] {
        PWG_DIV2,
        PWG_DIV4,
        PWG_DIV8,
        PWG_DIV16
    } pwg_div_t;

endpackage

// [hw/pwg_tick_if.sv]
`timescale 1ns/1ns

// ============================================================
// Tick request between control logic and prescaler
interface pwg_tick_if;
    logic run;
    pwg_pkg::pwg_div_t div;
    logic tick;

    modport ctrl (output run, output div, input tick);
    modport presc (input run, input div, output tick);
endinterface

// [hw/pwg_prescaler.sv]
`timescale 1ns/1ns
`include "pwg_defs.svh"

module pwg_prescaler (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Tick port
    pwg_tick_if.presc tk
);

    logic [3:0] divCnt;
    logic [4:0] span;
    logic [3:0] lastCnt;
    logic atLast;

    // ============================================================
    // Divide by 2, 4, 8 or 16; span needs five bits for 16
    assign span = 5'h02 << tk.div;
    assign lastCnt = 4'(span - 5'h01);
    assign atLast = (divCnt >= lastCnt);
    assign tk.tick = tk.run && atLast;

    // Prescale counter, cleared while stopped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt <= 4'h0;
        end else if (ce) begin
            if (!tk.run || atLast) begin
                divCnt <= 4'h0;
            end else begin
                divCnt <= divCnt + 4'h1;
            end
        end
    end

    // ============================================================
    // Checks
    property p_tick_gap;
        @(posedge clk) disable iff (!rst_n)
        ce && tk.tick |=> !tk.tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("two ticks in adjacent cycles");

    property p_div16;
        @(posedge clk) disable iff (!rst_n)
        ce && tk.tick && tk.div == pwg_pkg::PWG_DIV16
            |=> !tk.tick [*8];
    endproperty
    a_div16: assert property (p_div16)
        else $error("tick too soon after divide by 16");

endmodule

// [bench/pwg_pin_load.sv]
`timescale 1ns/1ns

// ============================================================
// Board load on the shared pin
module pwg_pin_load (
    // Pin as driven by the block
    input wire logic pinOut,
    input wire logic pinOe,
    // Level seen on the board
    output logic pinLevel
);
    // Pull-down resistor wins while nothing drives the pin
    assign pinLevel = pinOe ? pinOut : 1'b0;
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ns
`include "pwg_defs.svh"

// ============================================================
// Bench for the waveform generator
module tb_top;
    // Stimulus
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [9:0] addr = 10'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h0;
    logic gpioOut = 1'b0;
    logic gpioOe = 1'b0;
    // Observed
    logic [31:0] rdata;
    logic waitReq, pinOut, pinOe, waveOut, irq, pinLevel;
    logic [7:0] q;
    int n_mismatch = 0;
    int checked = 0;
    int hi, lo;

    pwg_wave_gen pwg_wave_gen_i (
        .clk(clk), .rst_n(rst_n), .ce(ce),
        .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(waitReq),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .pinOut(pinOut),
        .pinOe(pinOe), .waveOut(waveOut), .irq(irq)
    );

    pwg_pin_load pwg_pin_load_i (
        .pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel)
    );

    // Clock of 50 ns
    always #25 clk = ~clk;

    // ============================================================
    // Shared tasks
    task end_of_test;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, input logic [3:0] bytes);
        int i;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        be <= bytes;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (waitReq === 1'b0) break;
        end
        if (i == 50) begin
            n_mismatch++;
            end_of_test;
        end
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task wreg(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask

    task rreg(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00, 4'h1);
        check(q, exp);
    endtask

    // Stop, load period and duty, then start with a control value
    task setup(input logic [7:0] p, input logic [7:0] d,
               input logic [7:0] c);
        wreg(`PWG_IDX_CTRL, 8'h00);
        wreg(`PWG_IDX_PERIOD, p);
        wreg(`PWG_IDX_DUTY, d);
        wreg(`PWG_IDX_CTRL, c);
    endtask

    task automatic wait_act(input logic pol, input logic lvl);
        int i;
        for (i = 0; i < 3000 && (waveOut ^ pol) !== lvl; i++)
            @(posedge clk);
        if (i == 3000) begin
            n_mismatch++;
            end_of_test;
        end
    endtask

    // Active and idle lengths of one whole period, in clocks
    task measure(input logic pol);
        wait_act(pol, 1'b1);
        wait_act(pol, 1'b0);
        wait_act(pol, 1'b1);
        hi = 0;
        lo = 0;
        while ((waveOut ^ pol) === 1'b1 && hi < 3000) begin
            hi++;
            @(posedge clk);
        end
        while ((waveOut ^ pol) === 1'b0 && lo < 3000) begin
            lo++;
            @(posedge clk);
        end
    endtask

    task hold(input logic lvl);
        repeat (8) @(posedge clk);
        repeat (32) begin
            @(posedge clk);
            check(waveOut, lvl);
        end
    endtask

    // ============================================================
    // Scenarios
    task t_reset;
        check({waveOut, pinOe, irq}, 3'h0);
        rreg(`PWG_IDX_CTRL, 8'h00);
        rreg(`PWG_IDX_PERIOD, 8'h00);
        rreg(`PWG_IDX_DUTY, 8'h00);
        rreg(`PWG_IDX_MASK, 8'h00);
        bus(1'b1, `PWG_IDX_PERIOD, 8'h55, 4'h0);
        rreg(`PWG_IDX_PERIOD, 8'h00);
        wreg(8'hff, 8'h5a);
        rreg(8'hff, 8'h00);
    endtask

    task t_div;
        for (int s = 0; s < 4; s++) begin
            setup(8'h03, 8'h01, 8'h80 | 8'(s << 4));
            measure(1'b0);
            check(hi, 1 << (s + 1));
            check(lo, 2 << (s + 1));
        end
    endtask

    task t_pol;
        setup(8'h04, 8'h03, 8'hc0);
        measure(1'b1);
        check({hi[7:0], lo[7:0]}, 16'h0602);
        wreg(`PWG_IDX_CTRL, 8'h40);
        hold(1'b1);
    endtask

    task t_const;
        for (int p = 0; p < 2; p++) begin
            setup(8'h00, 8'h05, {1'b1, p[0], 6'h0});
            hold(p[0]);
            setup(8'h05, 8'h00, {1'b1, p[0], 6'h0});
            hold(p[0]);
            setup(8'h02, 8'h05, {1'b1, p[0], 6'h0});
            hold(!p[0]);
        end
    endtask

    task t_flag;
        wreg(`PWG_IDX_MASK, 8'h00);
        setup(8'h02, 8'h01, 8'h80);
        repeat (20) @(posedge clk);
        rreg(`PWG_IDX_CTRL, 8'h82);
        check(irq, 1'b0);
        wreg(`PWG_IDX_MASK, 8'h01);
        repeat (3) @(posedge clk);
        check(irq, 1'b1);
        wreg(`PWG_IDX_CTRL, 8'h02);
        repeat (20) @(posedge clk);
        rreg(`PWG_IDX_CTRL, 8'h02);
        wreg(`PWG_IDX_STATUS, 8'h01);
        rreg(`PWG_IDX_CTRL, 8'h00);
        wreg(`PWG_IDX_CTRL, 8'h80);
        repeat (20) @(posedge clk);
        wreg(`PWG_IDX_CTRL, 8'h00);
        rreg(`PWG_IDX_STATUS, 8'h00);
        repeat (3) @(posedge clk);
        check(irq, 1'b0);
    endtask

    task t_pin;
        gpioOut <= 1'b1;
        gpioOe <= 1'b1;
        setup(8'h02, 8'h01, 8'h80);
        repeat (20) @(posedge clk);
        check({pinOut, pinOe, pinLevel, irq}, 4'hf);
        gpioOut <= 1'b0;
        gpioOe <= 1'b0;
        repeat (3) @(posedge clk);
        check({pinOe, pinLevel}, 2'h0);
        setup(8'h00, 8'h00, 8'hc1);
        repeat (4) @(posedge clk);
        check({pinOut, pinOe, pinLevel}, 3'h7);
        wreg(`PWG_IDX_CTRL, 8'h81);
        repeat (4) @(posedge clk);
        check({pinOut, pinOe}, 2'h1);
        wreg(`PWG_IDX_CTRL, 8'h00);
    endtask

    task t_reload;
        setup(8'h04, 8'h02, 8'h80);
        measure(1'b0);
        check({hi[7:0], lo[7:0]}, 16'h0404);
        wreg(`PWG_IDX_PERIOD, 8'h08);
        measure(1'b0);
        check({hi[7:0], lo[7:0]}, 16'h040c);
    endtask

    // Clock enable low freezes the waveform, then it runs on
    task t_freeze;
        logic lvl;
        setup(8'h02, 8'h01, 8'h80);
        repeat (5) @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        lvl = waveOut;
        repeat (12) begin
            @(posedge clk);
            check(waveOut, lvl);
        end
        ce <= 1'b1;
        measure(1'b0);
        check({hi[7:0], lo[7:0]}, 16'h0202);
        wreg(`PWG_IDX_CTRL, 8'h00);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_div;
        t_pol;
        t_const;
        t_flag;
        t_pin;
        t_reload;
        t_freeze;
        end_of_test;
    end
endmodule
